// ### inc/pplc_map.svh
`ifndef PPLC_MAP_SVH
`define PPLC_MAP_SVH
// byte addresses of the register words
`define PPLC_OFF_CTRL  8'h00
`define PPLC_OFF_CMD   8'h04
`define PPLC_OFF_POL   8'h08
`define PPLC_OFF_MODE  8'h0C
`define PPLC_OFF_DOUT  8'h10
`define PPLC_OFF_DBIT  8'h14
`define PPLC_OFF_DIN   8'h18
`define PPLC_OFF_STAT  8'h1C
`define PPLC_OFF_ISTAT 8'h20
`define PPLC_OFF_IMASK 8'h24
// field positions
`define PPLC_CTRL_HS   0
`define PPLC_CTRL_RST  1
`define PPLC_CMD_IN    0
`define PPLC_CMD_RESET 1
`define PPLC_DBIT_VAL  8
`define PPLC_INT_IRQ   0
`define PPLC_INT_FLAG  1
`define PPLC_INT_STS   2
`define PPLC_INT_W     3
// reset values
`define PPLC_RST_DOUT  8'h00
`define PPLC_RST_IMASK 3'h0
// axi responses
`define PPLC_RESP_OKAY 2'b00
`define PPLC_RESP_SLV  2'b10
`endif

// ### inc/pplc_pkg.sv
package pplc_pkg;
  // negative polarity selects, one per line group
  typedef struct packed {
    logic ctl_neg;
    logic flag_neg;
    logic data_neg;
  } pplc_pol_s;

  typedef enum logic [2:0] {
    PPLC_HS_NONE   = 3'h0,
    PPLC_HS_LEAD   = 3'h1,
    PPLC_HS_TRAIL  = 3'h2,
    PPLC_HS_PULSE  = 3'h3,
    PPLC_HS_PART   = 3'h4,
    PPLC_HS_STROBE = 3'h5
  } pplc_hs_mode_e;

  typedef enum logic [1:0] {
    PPLC_WR_IDLE = 2'b01,
    PPLC_WR_RESP = 2'b10
  } pplc_wr_state_e;

  // every line that arrives from outside the clock domain
  typedef struct packed {
    logic       rst_pin;
    logic       dir_pin;
    logic       ctl_pin;
    logic       uts_n;
    logic       irq_n;
    logic       status;
    logic       flag;
    logic [7:0] data;
  } pplc_pin_in_s;
endpackage : pplc_pkg

// ### hdl/pplc_port.sv
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "pplc_map.svh"
module pplc_port (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // data lines
  input  wire logic [7:0]  data_i,
  output logic [7:0]       data_o,
  output logic             data_oe,
  // peripheral inputs
  input  wire logic        peripheral_flag,
  input  wire logic        peripheral_status_in,
  input  wire logic        peripheral_irq_in_n,
  input  wire logic        user_tristate_in_n,
  // open-collector lines
  input  wire logic        handshake_drive_i,
  output logic             handshake_drive_o,
  output logic             handshake_drive_oe,
  input  wire logic        direction_i,
  output logic             direction_o,
  output logic             direction_oe,
  input  wire logic        peripheral_reset_out_i,
  output logic             peripheral_reset_out_o,
  output logic             peripheral_reset_out_oe,
  // interrupt
  output logic             irq
);

  // keep a value while the last two stages disagree
  function automatic logic [14:0] settle(input logic [14:0] s2,
                                         input logic [14:0] s3,
                                         input logic [14:0] held);
    settle = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & held);
  endfunction : settle

  function automatic logic [31:0] strobe(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    strobe = (old & ~m) | (wd & m);
  endfunction : strobe

  pplc_pkg::pplc_pin_in_s   pin_now;
  pplc_pkg::pplc_pin_in_s   sync1;
  pplc_pkg::pplc_pin_in_s   sync2;
  pplc_pkg::pplc_pin_in_s   sync3;
  pplc_pkg::pplc_pin_in_s   pins;
  pplc_pkg::pplc_pin_in_s   pins_d;
  pplc_pkg::pplc_pol_s      pol;
  pplc_pkg::pplc_hs_mode_e  hs_mode;
  pplc_pkg::pplc_wr_state_e wr_state;

  logic        hs_drive;
  logic        rst_assert;
  logic        dir_input;
  logic [7:0]  dout;
  logic [2:0]  istat;
  logic [2:0]  imask;
  logic [2:0]  events;
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        wr_go;
  logic        wr_hit;
  logic [31:0] wr_val;
  logic        cmd_reset;
  logic        cmd_input;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [7:0]  din_logic;
  logic [31:0] dout_wr;

  assign pin_now = '{rst_pin: peripheral_reset_out_i,
                     dir_pin: direction_i,
                     ctl_pin: handshake_drive_i,
                     uts_n:   user_tristate_in_n,
                     irq_n:   peripheral_irq_in_n,
                     status:  peripheral_status_in,
                     flag:    peripheral_flag,
                     data:    data_i};

  // three stages; only the second and third feed the filter
  // reset starts every line at its pull-up level to avoid a false edge; all but the handshake line, which the port pulls low from reset, idle there
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sync1  <= '1;
      sync2  <= '1;
      sync3  <= '1;
      pins   <= '1;
      pins_d <= '1;
    end else begin
      sync1  <= pin_now;
      sync2  <= sync1;
      sync3  <= sync2;
      pins   <= settle(sync2, sync3, pins);
      pins_d <= pins;
    end
  end

  // ---------------- axi write ----------------
  assign wr_go  = (wr_state == pplc_pkg::PPLC_WR_IDLE) && aw_held && w_held;
  assign wr_val = strobe(32'h0000_0000, w_data, w_strb);
  assign dout_wr = strobe({24'h00_0000, dout}, w_data, w_strb);

  always_comb begin
    wr_hit = 1'b1;
    case (aw_addr)
      `PPLC_OFF_CTRL, `PPLC_OFF_CMD, `PPLC_OFF_POL, `PPLC_OFF_MODE,
      `PPLC_OFF_DOUT, `PPLC_OFF_DBIT, `PPLC_OFF_ISTAT,
      `PPLC_OFF_IMASK: wr_hit = 1'b1;
      default:         wr_hit = 1'b0;
    endcase
  end

  assign cmd_reset = wr_go && (aw_addr == `PPLC_OFF_CMD) && wr_val[`PPLC_CMD_RESET];
  assign cmd_input = wr_go && (aw_addr == `PPLC_OFF_CMD) && wr_val[`PPLC_CMD_IN];

  // address and data are taken in either order and held until the write is done
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      aw_addr       <= {s_axi_awaddr[7:2], 2'b00};
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held       <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_state     <= pplc_pkg::PPLC_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PPLC_RESP_OKAY;
    end else begin
      case (wr_state)
        pplc_pkg::PPLC_WR_IDLE: begin
          if (wr_go) begin
            wr_state     <= pplc_pkg::PPLC_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `PPLC_RESP_OKAY : `PPLC_RESP_SLV;
          end
        end
        pplc_pkg::PPLC_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state     <= pplc_pkg::PPLC_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state     <= pplc_pkg::PPLC_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // ---------------- port control state ----------------
  // handshake drive held as its logical value; pin level derived below
  always_ff @(posedge sys_clk) begin
    if (!reset_n || cmd_reset) begin
      hs_drive <= 1'b0;
    end else if (wr_go && aw_addr == `PPLC_OFF_CTRL && w_strb[0]) begin
      hs_drive <= w_data[`PPLC_CTRL_HS];
    end
  end

  // the reset line is outside the reset command's reach on purpose:
  // software may want to hold the peripheral in reset across it
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rst_assert <= 1'b0;
    end else if (wr_go && aw_addr == `PPLC_OFF_CTRL && w_strb[0]) begin
      rst_assert <= w_data[`PPLC_CTRL_RST];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || cmd_reset) begin
      pol <= '0;
    end else if (wr_go && aw_addr == `PPLC_OFF_POL && w_strb[0]) begin
      pol <= w_data[2:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || cmd_reset) begin
      hs_mode <= pplc_pkg::PPLC_HS_NONE;
    end else if (wr_go && aw_addr == `PPLC_OFF_MODE && w_strb[0]) begin
      hs_mode <= pplc_pkg::pplc_hs_mode_e'(w_data[2:0]);
    end
  end

  // direction is only a side effect of input and output operations and of the reset command
  always_ff @(posedge sys_clk) begin
    if (!reset_n || cmd_reset) begin
      dir_input <= 1'b1;
    end else if (cmd_input) begin
      dir_input <= 1'b1;
    end else if (wr_go && (aw_addr == `PPLC_OFF_DOUT || aw_addr == `PPLC_OFF_DBIT)) begin
      dir_input <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dout <= `PPLC_RST_DOUT;
    end else if (wr_go && aw_addr == `PPLC_OFF_DOUT) begin
      dout <= dout_wr[7:0];
    end else if (wr_go && aw_addr == `PPLC_OFF_DBIT && w_strb[1:0] == 2'b11) begin
      dout[w_data[2:0]] <= w_data[`PPLC_DBIT_VAL];
    end
  end

  // ---------------- interrupts ----------------
  assign events[`PPLC_INT_IRQ]  = !pins.irq_n;
  assign events[`PPLC_INT_FLAG] = pins.flag != pins_d.flag;
  assign events[`PPLC_INT_STS]  = pins.status != pins_d.status;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      istat <= 3'h0;
    end else if (wr_go && aw_addr == `PPLC_OFF_ISTAT && w_strb[0]) begin
      istat <= (istat & ~w_data[2:0]) | events;
    end else begin
      istat <= istat | events;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      imask <= `PPLC_RST_IMASK;
    end else if (wr_go && aw_addr == `PPLC_OFF_IMASK && w_strb[0]) begin
      imask <= w_data[2:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat & imask);
    end
  end

  // ---------------- axi read ----------------
  assign din_logic = pins.data ^ {8{pol.data_neg}};

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `PPLC_OFF_CTRL:  rd_val = {30'h0000_0000, rst_assert, hs_drive};
      `PPLC_OFF_CMD:   rd_val = 32'h0000_0000;
      `PPLC_OFF_POL:   rd_val = {29'h0000_0000, pol};
      `PPLC_OFF_MODE:  rd_val = {29'h0000_0000, hs_mode};
      `PPLC_OFF_DOUT:  rd_val = {24'h00_0000, dout};
      `PPLC_OFF_DBIT:  rd_val = 32'h0000_0000;
      `PPLC_OFF_DIN:   rd_val = {24'h00_0000, din_logic};
      `PPLC_OFF_STAT:  rd_val = {24'h00_0000,
                                 pins.rst_pin, pins.dir_pin, pins.ctl_pin, pins.uts_n,
                                 dir_input, !pins.irq_n, pins.status,
                                 pins.flag ^ pol.flag_neg};
      `PPLC_OFF_ISTAT: rd_val = {29'h0000_0000, istat};
      `PPLC_OFF_IMASK: rd_val = {29'h0000_0000, imask};
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PPLC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? `PPLC_RESP_OKAY : `PPLC_RESP_SLV;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ---------------- pins ----------------
  // open-collector lines: output value is always low, enable pulls the wire
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      handshake_drive_o       <= 1'b0;
      direction_o             <= 1'b0;
      peripheral_reset_out_o  <= 1'b0;
      handshake_drive_oe      <= 1'b1;
      direction_oe            <= 1'b0;
      peripheral_reset_out_oe <= 1'b0;
    end else begin
      handshake_drive_o       <= 1'b0;
      direction_o             <= 1'b0;
      peripheral_reset_out_o  <= 1'b0;
      handshake_drive_oe      <= !(hs_drive ^ pol.ctl_neg);
      direction_oe            <= !dir_input;
      peripheral_reset_out_oe <= rst_assert;
    end
  end

  // peripheral keeps its drivers off while we drive
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      data_o  <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_o  <= dout ^ {8{pol.data_neg}};
      data_oe <= !dir_input && pins.uts_n;
    end
  end

endmodule : pplc_port

// ### tb/pplc_port_checker.sv
`timescale 1ns/1ps
module pplc_port_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pins
  input wire logic        data_oe,
  input wire logic        user_tristate_in_n,
  input wire logic        handshake_drive_o,
  input wire logic        handshake_drive_oe,
  input wire logic        direction_o,
  input wire logic        direction_oe,
  input wire logic        peripheral_reset_out_o,
  input wire logic        peripheral_reset_out_oe,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  reset_state_a: assert property ($rose(reset_n) |-> handshake_drive_oe && !direction_oe
    && !data_oe && !irq) else $error("port lines not at reset state");
  open_drain_a: assert property (!handshake_drive_o && !direction_o
    && !peripheral_reset_out_o) else $error("open-collector line driven high");
  dir_gates_data_a: assert property (data_oe |-> direction_oe || $past(direction_oe))
    else $error("data driven while direction says input");
  uts_float_a: assert property (!user_tristate_in_n [*6] |-> !data_oe)
    else $error("data driven while user tristate low");
  // these lines move only as a consequence of a register write
  pin_by_write_a: assert property ($changed({direction_oe, handshake_drive_oe,
    peripheral_reset_out_oe}) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("control line changed without a write");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");

  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property ($rose(irq));
  cover property ($rose(data_oe));
  cover property (!user_tristate_in_n [*6]);
endmodule : pplc_port_checker

bind pplc_port pplc_port_checker u_chk (.*);

// ### tb/pplc_periph.sv
`timescale 1ns/1ps
module pplc_periph (
  // port side
  input wire logic [7:0] data_o,
  input wire logic       data_oe,
  input wire logic       handshake_drive_oe,
  input wire logic       direction_oe,
  input wire logic       peripheral_reset_out_oe,
  // peripheral side
  input wire logic [7:0] send_byte,
  input wire logic       send_en,
  // resolved wires
  output logic [7:0]     data_i,
  output logic           handshake_drive_i,
  output logic           direction_i,
  output logic           peripheral_reset_out_i,
  output logic           clash
);
  logic drv;
  // external pull-ups: high unless the port pulls low
  assign handshake_drive_i      = !handshake_drive_oe;
  assign direction_i            = !direction_oe;
  assign peripheral_reset_out_i = !peripheral_reset_out_oe;
  // drive only while the port signals input
  assign drv    = send_en && direction_i;
  // termination pulls undriven data lines high
  assign data_i = data_oe ? data_o : (drv ? send_byte : 8'hff);
  assign clash  = data_oe && drv;
endmodule : pplc_periph

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "pplc_map.svh"
module tb_top;
  logic        sys_clk, reset_n, b;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, data_i, data_o, send_byte, v, dout;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        data_oe, peripheral_flag, peripheral_status_in, peripheral_irq_in_n;
  logic        user_tristate_in_n, irq, send_en, clash;
  logic        handshake_drive_i, handshake_drive_o, handshake_drive_oe;
  logic        direction_i, direction_o, direction_oe;
  logic        peripheral_reset_out_i, peripheral_reset_out_o, peripheral_reset_out_oe;
  int          num_errors, checked;

  pplc_port dut (.*);
  pplc_periph u_periph (.*);

  task automatic tally_and_finish;
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic bound(input int k);
    if (k >= 64) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : bound

  task automatic idle(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int k = 0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 64);
    s_axi_bready <= 1'b0;
    bound(k);
    check(s_axi_bresp, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hffff_ffff, input logic [1:0] er = 2'h0);
    int k = 0;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 64);
    s_axi_rready <= 1'b0;
    bound(k);
    check(s_axi_rdata & m, exp);
    check(s_axi_rresp, er);
  endtask : rd

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {send_en, peripheral_status_in} = '0;
    {peripheral_flag, peripheral_irq_in_n, user_tristate_in_n} = 3'h7;
    {s_axi_awaddr, s_axi_araddr, send_byte, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    num_errors  = 0;
    checked     = 0;
    void'($urandom(49));
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    idle(8);
    rd(`PPLC_OFF_CTRL, 32'h0);
    rd(`PPLC_OFF_POL, 32'h0);
    rd(`PPLC_OFF_MODE, 32'h0);
    rd(`PPLC_OFF_STAT, 32'hd9);
    rd(`PPLC_OFF_DIN, 32'hff);
    peripheral_status_in <= 1'b1;
    idle(8);
    rd(`PPLC_OFF_STAT, 32'h2, 32'h2);
    // handshake drive written, read back and inverted
    wr(`PPLC_OFF_CTRL, 32'h1);
    idle(2);
    check(handshake_drive_i, 1'b1);
    rd(`PPLC_OFF_CTRL, 32'h1);
    wr(`PPLC_OFF_POL, 32'h4);
    idle(2);
    check(handshake_drive_i, 1'b0);
    for (int p = 0; p < 2; p++) begin
      wr(`PPLC_OFF_POL, 32'(p) << 1);
      for (int f = 0; f < 2; f++) begin
        peripheral_flag <= f[0];
        idle(8);
        rd(`PPLC_OFF_STAT, 32'(f ^ p), 32'h1);
      end
    end
    for (int p = 0; p < 2; p++) begin
      v = 8'($urandom);
      wr(`PPLC_OFF_POL, 32'(p));
      wr(`PPLC_OFF_DOUT, {24'h00_0000, v});
      idle(2);
      check(data_i, {v ^ {8{p[0]}}});
      check(direction_i, 1'b0);
      rd(`PPLC_OFF_DOUT, {24'h00_0000, v});
    end
    dout = v;
    for (int i = 0; i < 8; i++) begin
      b = 1'($urandom);
      wr(`PPLC_OFF_DBIT, {23'h00_0000, b, 5'h00, i[2:0]});
      dout[i] = b;
      idle(2);
      check(data_i, {~dout});
    end
    user_tristate_in_n <= 1'b0;
    idle(8);
    check(data_oe, 1'b0);
    check(data_i, 8'hff);
    user_tristate_in_n <= 1'b1;
    idle(8);
    check(data_i, {~dout});
    wr(`PPLC_OFF_CMD, 32'h1);
    v = 8'($urandom);
    send_byte <= v;
    send_en   <= 1'b1;
    idle(8);
    check(direction_i, 1'b1);
    check(data_oe, 1'b0);
    rd(`PPLC_OFF_DIN, {24'h00_0000, ~v}, 32'hff);
    wr(`PPLC_OFF_POL, 32'h0);
    rd(`PPLC_OFF_DIN, {24'h00_0000, v}, 32'hff);
    wr(`PPLC_OFF_CTRL, 32'h2);
    idle(2);
    check(peripheral_reset_out_i, 1'b0);
    // the status view of the pin trails it by the sync chain
    idle(4);
    rd(`PPLC_OFF_STAT, 32'h0, 32'h80);
    // interrupt raised, cleared, then masked
    wr(`PPLC_OFF_ISTAT, 32'h7);
    wr(`PPLC_OFF_IMASK, 32'h1);
    peripheral_irq_in_n <= 1'b0;
    idle(8);
    check(irq, 1'b1);
    rd(`PPLC_OFF_ISTAT, 32'h1, 32'h1);
    peripheral_irq_in_n <= 1'b1;
    idle(8);
    wr(`PPLC_OFF_ISTAT, 32'h1);
    idle(2);
    check(irq, 1'b0);
    wr(`PPLC_OFF_IMASK, 32'h0);
    peripheral_irq_in_n <= 1'b0;
    idle(8);
    check(irq, 1'b0);
    rd(`PPLC_OFF_STAT, 32'h4, 32'h4);
    peripheral_irq_in_n <= 1'b1;
    for (int m = 0; m < 6; m++) begin
      wr(`PPLC_OFF_MODE, 32'(m));
      rd(`PPLC_OFF_MODE, 32'(m));
    end
    send_en <= 1'b0;
    wr(`PPLC_OFF_CTRL, 32'h3);
    wr(`PPLC_OFF_POL, 32'h7);
    wr(`PPLC_OFF_DOUT, 32'h0);
    wr(`PPLC_OFF_CMD, 32'h2);
    idle(2);
    rd(`PPLC_OFF_CTRL, 32'h2);
    rd(`PPLC_OFF_POL, 32'h0);
    rd(`PPLC_OFF_MODE, 32'h0);
    check(handshake_drive_i, 1'b0);
    check(direction_i, 1'b1);
    // unmapped word answers with an error and reads zero
    wr(8'h30, 32'h1, `PPLC_RESP_SLV);
    rd(8'h30, 32'h0, 32'hffff_ffff, `PPLC_RESP_SLV);
    check(clash, 1'b0);
    tally_and_finish();
  end
endmodule : tb_top
